// ==== pp_pkg.sv ====
package pp_pkg;
  // ****************************************
  // opcodes
  // ****************************************
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_DPP = 8'hA2;
  localparam logic [7:0] OP_EDPP = 8'hD2;
  localparam logic [7:0] OP_QPP = 8'h32;
  localparam logic [7:0] OP_EQPP = 8'h38;
  localparam logic [7:0] OP_SUSP = 8'h75;
  localparam logic [7:0] OP_RESM = 8'h7A;
  // ****************************************
  // geometry and layout
  // ****************************************
  localparam int PAGE_BYTES = 256;
  localparam int PAGE_AW = 8;
  localparam int ADDR_W = 24;
  localparam int SECT_LSB = 16;
  localparam int SECT_W = 8;
  localparam int NSECT = 256;
  // status register bit positions
  localparam int SR_WIP = 0;
  localparam int SR_WEL = 1;
  // flag status register bit positions
  localparam int FS_PROT = 1;
  localparam int FS_PSUSP = 2;
  localparam int FS_PFAIL = 4;
  localparam int FS_READY = 7;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 250;
  localparam int PROG_US = 120;
  localparam int PROG_CYC = PROG_US * CLK_MHZ;
  localparam int TMO_CYC = 2 * PROG_CYC;
  localparam int CNT_W = 20;
  localparam logic [2:0] SYNC_HI = 3'h6;
  localparam logic [2:0] SYNC_RISE = 3'h6;
endpackage

// ==== pp_page_buf.sv ====
`timescale 1ns/1ps
// page latch: bytes start erased (FF) so untouched bytes leave memory alone
module pp_page_buf (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control
  input wire logic clr,
  input wire logic wr,
  input wire logic [pp_pkg::PAGE_AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [pp_pkg::PAGE_AW-1:0] raddr,
  // read
  output logic [7:0] rdata
);
  typedef struct packed {
    logic [pp_pkg::PAGE_BYTES-1:0][7:0] mem;
  } buf_s;
  buf_s st_r;
  buf_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (clr) begin
      for (int i = 0; i < pp_pkg::PAGE_BYTES; i++) begin
        st_nxt.mem[i] = 8'hFF;
      end
    end else if (wr) begin
      // later byte at same address overwrites the earlier one
      st_nxt.mem[waddr] = wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.mem[raddr];
endmodule

// ==== pp_sequencer.sv ====
`timescale 1ns/1ps
module pp_sequencer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // serial link
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic [3:0] dq,
  // protection and array
  input wire logic [pp_pkg::NSECT-1:0] sect_prot,
  input wire logic [7:0] array_rdata,
  input wire logic prog_fail_inj,
  input wire logic clr_flags,
  output logic [pp_pkg::ADDR_W-1:0] array_addr,
  output logic [7:0] array_wdata,
  output logic array_we,
  // status
  output logic [7:0] status,
  output logic [7:0] flag_status
);
  typedef enum logic [2:0] {IDLE, CMD, ADDR, DATA, PROG, SUSP, DONE} st_e;
  typedef struct packed {
    logic [2:0] sclk_s;
    logic [2:0] seln_s;
    logic [2:0][3:0] dq_s;
    logic sclk_lvl;
    logic seln_lvl;
    st_e st;
    logic [7:0] op;
    logic [4:0] bitc;
    logic [pp_pkg::ADDR_W-1:0] addr;
    logic [7:0] sh;
    logic [2:0] lanes;
    logic [pp_pkg::PAGE_AW-1:0] wptr;
    logic [pp_pkg::PAGE_AW:0] pidx;
    logic [pp_pkg::CNT_W-1:0] cnt;
    logic wel;
    logic wip;
    logic prot;
    logic pfail;
    logic psusp;
    logic bclr;
    logic bwr;
    logic we;
    logic [7:0] wd;
  } seq_s;
  seq_s s_r;
  seq_s s_nxt;
  logic [7:0] buf_rd;

  localparam logic [pp_pkg::CNT_W-1:0] PROG_CNT = pp_pkg::CNT_W'(pp_pkg::PROG_CYC / pp_pkg::PAGE_BYTES);
  localparam logic [pp_pkg::CNT_W-1:0] TMO_CNT = pp_pkg::CNT_W'(pp_pkg::TMO_CYC / pp_pkg::PAGE_BYTES);

  // ****************************************
  // page latch
  // ****************************************
  pp_page_buf u_buf (
    .ref_clk(ref_clk),
    .rst(rst),
    .clr(s_r.bclr),
    .wr(s_r.bwr),
    .waddr(s_r.wptr),
    .wdata(s_r.sh),
    .raddr(s_r.pidx[pp_pkg::PAGE_AW-1:0]),
    .rdata(buf_rd)
  );

  // ****************************************
  // sequencer
  // ****************************************
  logic rise;
  logic seln_hi;
  logic seln_fall;
  logic seln_rise;
  logic [7:0] shin;
  logic [4:0] nb;
  logic prog_op;

  always_comb begin
    s_nxt = s_r;
    s_nxt.sclk_s = {s_r.sclk_s[1:0], sclk};
    s_nxt.seln_s = {s_r.seln_s[1:0], sel_n};
    s_nxt.dq_s = {s_r.dq_s[1:0], dq};
    s_nxt.bclr = 1'b0;
    s_nxt.bwr = 1'b0;
    s_nxt.we = 1'b0;
    // an edge counts once, when the second and third stages agree on the new level
    if (s_r.sclk_s[2] == s_r.sclk_s[1]) begin
      s_nxt.sclk_lvl = s_r.sclk_s[2];
    end
    if (s_r.seln_s[2] == s_r.seln_s[1]) begin
      s_nxt.seln_lvl = s_r.seln_s[2];
    end
    rise = s_r.sclk_s[2] & s_r.sclk_s[1] & ~s_r.sclk_lvl;
    seln_hi = s_r.seln_s[2] & s_r.seln_s[1];
    seln_rise = s_r.seln_s[2] & s_r.seln_s[1] & ~s_r.seln_lvl;
    seln_fall = ~s_r.seln_s[2] & ~s_r.seln_s[1] & s_r.seln_lvl;
    case (s_r.lanes)
      3'h4: shin = {s_r.sh[3:0], s_r.dq_s[2]};
      3'h2: shin = {s_r.sh[5:0], s_r.dq_s[2][1:0]};
      default: shin = {s_r.sh[6:0], s_r.dq_s[2][0]};
    endcase
    nb = s_r.bitc + 5'(s_r.lanes);
    prog_op = (s_r.op == pp_pkg::OP_PP) || (s_r.op == pp_pkg::OP_DPP) || (s_r.op == pp_pkg::OP_EDPP) ||
              (s_r.op == pp_pkg::OP_QPP) || (s_r.op == pp_pkg::OP_EQPP);
    if (clr_flags) begin
      s_nxt.prot = 1'b0;
      s_nxt.pfail = 1'b0;
    end
    case (s_r.st)
      IDLE: begin
        if (seln_fall) begin
          s_nxt.st = CMD;
          s_nxt.bitc = '0;
          s_nxt.lanes = 3'h1;
        end
      end
      CMD: begin
        if (seln_hi) begin
          s_nxt.st = IDLE;
        end else if (rise) begin
          s_nxt.sh = shin;
          s_nxt.bitc = nb;
          if (nb == 5'h08) begin
            s_nxt.op = shin;
            s_nxt.bitc = '0;
            s_nxt.st = IDLE;
            if (shin == pp_pkg::OP_WREN) begin
              s_nxt.wel = 1'b1;
            end else if ((shin == pp_pkg::OP_PP || shin == pp_pkg::OP_DPP || shin == pp_pkg::OP_EDPP ||
                          shin == pp_pkg::OP_QPP || shin == pp_pkg::OP_EQPP) && s_r.wel) begin
              s_nxt.st = ADDR;
              s_nxt.bclr = 1'b1;
              if (shin == pp_pkg::OP_EDPP) begin
                s_nxt.lanes = 3'h2;
              end else if (shin == pp_pkg::OP_EQPP) begin
                s_nxt.lanes = 3'h4;
              end
            end
          end
        end
      end
      ADDR: begin
        if (seln_hi) begin
          s_nxt.st = IDLE;
        end else if (rise) begin
          s_nxt.addr = {s_r.addr[pp_pkg::ADDR_W-2:0], s_r.dq_s[2][0]};
          if (s_r.lanes == 3'h4) begin
            s_nxt.addr = {s_r.addr[pp_pkg::ADDR_W-5:0], s_r.dq_s[2]};
          end else if (s_r.lanes == 3'h2) begin
            s_nxt.addr = {s_r.addr[pp_pkg::ADDR_W-3:0], s_r.dq_s[2][1:0]};
          end
          s_nxt.bitc = nb;
          if (nb == 5'(pp_pkg::ADDR_W)) begin
            s_nxt.st = DATA;
            s_nxt.bitc = '0;
            s_nxt.wptr = s_nxt.addr[pp_pkg::PAGE_AW-1:0];
            if (s_r.op == pp_pkg::OP_DPP) begin
              s_nxt.lanes = 3'h2;
            end else if (s_r.op == pp_pkg::OP_QPP) begin
              s_nxt.lanes = 3'h4;
            end
          end
        end
      end
      DATA: begin
        if (seln_rise) begin
          s_nxt.st = IDLE;
          if (s_r.bitc == 5'h00 && prog_op) begin
            if (sect_prot[s_r.addr[pp_pkg::SECT_LSB +: pp_pkg::SECT_W]]) begin
              s_nxt.prot = 1'b1;
              s_nxt.pfail = 1'b1;
            end else begin
              s_nxt.st = PROG;
              s_nxt.wip = 1'b1;
              s_nxt.pidx = '0;
              s_nxt.cnt = '0;
            end
          end
        end else if (rise) begin
          s_nxt.sh = shin;
          s_nxt.bitc = nb;
          if (nb == 5'h08) begin
            s_nxt.bitc = '0;
            s_nxt.bwr = 1'b1;
          end
        end
        if (s_r.bwr) begin
          s_nxt.wptr = s_r.wptr + pp_pkg::PAGE_AW'(1'b1);
        end
      end
      PROG: begin
        s_nxt.cnt = s_r.cnt + pp_pkg::CNT_W'(1'b1);
        // commands during a program arrive on one line
        if (seln_fall) begin
          s_nxt.bitc = '0;
          s_nxt.lanes = 3'h1;
        end
        if (!seln_hi && rise) begin
          s_nxt.sh = shin;
          s_nxt.bitc = nb;
          if (nb == 5'h08 && shin == pp_pkg::OP_SUSP) begin
            s_nxt.st = SUSP;
            s_nxt.psusp = 1'b1;
          end
        end
        if (prog_fail_inj && s_r.cnt == TMO_CNT) begin
          s_nxt.st = DONE;
          s_nxt.pfail = 1'b1;
        end else if (!prog_fail_inj && s_r.cnt == PROG_CNT) begin
          s_nxt.cnt = '0;
          s_nxt.we = 1'b1;
          s_nxt.wd = array_rdata & buf_rd;
          s_nxt.pidx = s_r.pidx + {{pp_pkg::PAGE_AW{1'b0}}, 1'b1};
          if (s_r.pidx == 9'(pp_pkg::PAGE_BYTES - 1)) begin
            s_nxt.st = DONE;
          end
        end
      end
      SUSP: begin
        if (seln_fall) begin
          s_nxt.bitc = '0;
          s_nxt.lanes = 3'h1;
        end
        if (!seln_hi && rise) begin
          s_nxt.sh = shin;
          s_nxt.bitc = nb;
          if (nb == 5'h08 && shin == pp_pkg::OP_RESM) begin
            s_nxt.st = PROG;
            s_nxt.psusp = 1'b0;
          end
        end
      end
      DONE: begin
        s_nxt.wel = 1'b0;
        s_nxt.wip = 1'b0;
        s_nxt.st = IDLE;
      end
      default: s_nxt.st = IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.seln_s <= '1;
      s_r.seln_lvl <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  logic [pp_pkg::PAGE_AW-1:0] widx;
  assign widx = s_r.pidx[pp_pkg::PAGE_AW-1:0] - pp_pkg::PAGE_AW'(1'b1);
  assign array_addr = s_r.we ? {s_r.addr[pp_pkg::ADDR_W-1:pp_pkg::PAGE_AW], widx} :
                      {s_r.addr[pp_pkg::ADDR_W-1:pp_pkg::PAGE_AW], s_r.pidx[pp_pkg::PAGE_AW-1:0]};
  assign array_wdata = s_r.wd;
  assign array_we = s_r.we;
  always_comb begin
    status = 8'h00;
    status[pp_pkg::SR_WIP] = s_r.wip;
    status[pp_pkg::SR_WEL] = s_r.wel;
    flag_status = 8'h00;
    flag_status[pp_pkg::FS_READY] = ~s_r.wip | s_r.psusp;
    flag_status[pp_pkg::FS_PROT] = s_r.prot;
    flag_status[pp_pkg::FS_PFAIL] = s_r.pfail;
    flag_status[pp_pkg::FS_PSUSP] = s_r.psusp;
  end
endmodule

// ==== pp_asserts.sv ====
`timescale 1ns/1ps
// ****************************************
// port checks of the page program sequencer
// ****************************************
module pp_asserts (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // link and array
  input wire logic sel_n,
  input wire logic [pp_pkg::NSECT-1:0] sect_prot,
  input wire logic [7:0] array_rdata,
  input wire logic [pp_pkg::ADDR_W-1:0] array_addr,
  input wire logic [7:0] array_wdata,
  input wire logic array_we,
  // status
  input wire logic [7:0] status,
  input wire logic [7:0] flag_status
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_we_single_pulse: assert property (array_we |=> !array_we)
    else $error("write strobe too long");
  a_only_clear_bits: assert property (array_we |-> (array_wdata & ~array_rdata) == 8'h00)
    else $error("program sets a bit");
  a_we_while_busy: assert property (array_we |-> status[pp_pkg::SR_WIP])
    else $error("write while idle");
  a_wel_drop_end: assert property ($fell(status[pp_pkg::SR_WIP]) |-> !status[pp_pkg::SR_WEL])
    else $error("latch kept after program");
  a_busy_after_sel: assert property ($rose(status[pp_pkg::SR_WIP]) |-> sel_n && $past(sel_n) && status[pp_pkg::SR_WEL])
    else $error("busy without release");
  a_prot_keep_wel: assert property ($rose(flag_status[pp_pkg::FS_PROT]) |->
    status[pp_pkg::SR_WEL] && !status[pp_pkg::SR_WIP] && flag_status[pp_pkg::FS_PFAIL])
    else $error("protect flags wrong");
  a_no_we_protected: assert property (array_we |-> !sect_prot[array_addr[pp_pkg::SECT_LSB +: pp_pkg::SECT_W]])
    else $error("protected sector written");
  a_fail_drops_wel: assert property ($rose(flag_status[pp_pkg::FS_PFAIL]) |->
    ##[0:2] (!status[pp_pkg::SR_WEL] || flag_status[pp_pkg::FS_PROT]))
    else $error("fail keeps latch");
endmodule

bind pp_sequencer pp_asserts i_chk (.ref_clk(ref_clk), .rst(rst), .sel_n(sel_n), .sect_prot(sect_prot),
  .array_rdata(array_rdata), .array_addr(array_addr), .array_wdata(array_wdata), .array_we(array_we),
  .status(status), .flag_status(flag_status));

// ==== pp_host.sv ====
`timescale 1ns/1ps
// ****************************************
// serial host model, clock stands low between frames
// ****************************************
module pp_host (
  // serial link
  output logic sclk,
  output logic sel_n,
  output logic [3:0] dq
);
  logic [7:0] dat [$];
  initial begin
    sclk = 1'b0;
    sel_n = 1'b1;
    dq = 4'h0;
  end
  task automatic put(input logic [7:0] b, input int w);
    for (int i = 8 - w; i >= 0; i -= w) begin
      dq <= 4'((b >> i) & ((1 << w) - 1));
      #8 sclk <= 1'b1;
      #16 sclk <= 1'b0;
      #8;
    end
  endtask
  // extra: single clocks added before release, breaking the byte boundary
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int extra);
    int aw;
    int w;
    aw = (op == pp_pkg::OP_EDPP) ? 2 : (op == pp_pkg::OP_EQPP) ? 4 : 1;
    w = (op == pp_pkg::OP_PP) ? 1 : (op == pp_pkg::OP_DPP || op == pp_pkg::OP_EDPP) ? 2 : 4;
    sel_n <= 1'b0;
    #16 put(op, 1);
    if (op != pp_pkg::OP_WREN && op != pp_pkg::OP_SUSP && op != pp_pkg::OP_RESM) begin
      for (int k = 16; k >= 0; k -= 8) put(a[k+:8], aw);
      foreach (dat[j]) put(dat[j], w);
    end
    repeat (extra) put(8'h00, 8);
    #16 sel_n <= 1'b1;
    dq <= ~dq;
    #64;
  endtask
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
// ****************************************
// testbench
// ****************************************
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [pp_pkg::NSECT-1:0] sect_prot = '0;
  logic prog_fail_inj = 1'b0;
  logic clr_flags = 1'b0;
  logic sclk;
  logic sel_n;
  logic [3:0] dq;
  logic [23:0] array_addr;
  logic [7:0] array_wdata;
  logic [7:0] array_rdata;
  logic [7:0] status;
  logic [7:0] flag_status;
  logic array_we;
  logic [7:0] mem [256];
  logic [7:0] mem_init [256];
  logic [31:0] exp_q [$];
  logic watch = 1'b1;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  always #2 ref_clk = ~ref_clk;
  pp_host i_host (.sclk(sclk), .sel_n(sel_n), .dq(dq));
  pp_sequencer i_dut (.ref_clk(ref_clk), .rst(rst), .sclk(sclk), .sel_n(sel_n), .dq(dq),
    .sect_prot(sect_prot), .array_rdata(array_rdata), .prog_fail_inj(prog_fail_inj),
    .clr_flags(clr_flags), .array_addr(array_addr), .array_wdata(array_wdata),
    .array_we(array_we), .status(status), .flag_status(flag_status));
  assign array_rdata = mem[array_addr[7:0]];
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic settle(input int n);
    for (int i = 0; i < n && status[0] !== 1'b0; i++) @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
  endtask
  // write watcher: each strobe takes the oldest expected write
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 0) begin
      mem <= mem_init;
    end else if (array_we) begin
      mem[array_addr[7:0]] <= array_wdata;
      if (watch) chk({array_addr, array_wdata}, exp_q.pop_front());
    end
    if (cyc == 99000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    logic [7:0] lat [256];
    logic [7:0] ops [5];
    ops = '{pp_pkg::OP_PP, pp_pkg::OP_DPP, pp_pkg::OP_EDPP, pp_pkg::OP_QPP, pp_pkg::OP_EQPP};
    void'($urandom(32'h31357057));
    foreach (mem_init[i]) mem_init[i] = 8'($urandom);
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    i_host.frame(pp_pkg::OP_WREN, 24'h0, 0);
    i_host.dat = {8'h00};
    i_host.frame(pp_pkg::OP_PP, 24'h010500, 3);
    settle(40);
    chk({status[1:0], flag_status[4], flag_status[1]}, 32'h8);
    $display("off boundary test done");
    @(posedge ref_clk) sect_prot[2] <= 1'b1;
    foreach (ops[i]) begin
      i_host.frame(ops[i], 24'h0200F0, 0);
      settle(40);
      chk({status[1:0], flag_status[4], flag_status[1]}, 32'hB);
      @(posedge ref_clk) clr_flags <= 1'b1;
      @(posedge ref_clk) clr_flags <= 1'b0;
    end
    $display("protected sector test done");
    foreach (lat[p]) lat[p] = 8'hFF;
    i_host.dat = {};
    for (int k = 0; k < 258; k++) begin
      i_host.dat.push_back(8'($urandom));
      lat[8'(8'hFE + k)] = i_host.dat[k];
    end
    foreach (lat[p]) exp_q.push_back({16'h0105, 8'(p), mem[p] & lat[p]});
    i_host.frame(pp_pkg::OP_WREN, 24'h0, 0);
    i_host.frame(pp_pkg::OP_QPP, 24'h0105FE, 0);
    chk({status[1:0], flag_status[4], flag_status[1]}, 32'hC);
    i_host.frame(pp_pkg::OP_SUSP, 24'h0, 0);
    chk({status[0], flag_status[7], flag_status[2]}, 32'h7);
    i_host.frame(pp_pkg::OP_RESM, 24'h0, 0);
    chk({status[0], flag_status[7], flag_status[2]}, 32'h4);
    settle(40000);
    chk({status[1:0], flag_status[4], flag_status[1], 8'(exp_q.size())}, 32'h0);
    $display("wrapped overflow test done");
    foreach (lat[p]) lat[p] = 8'hFF;
    i_host.dat = {};
    for (int k = 0; k < 3; k++) begin
      i_host.dat.push_back(8'($urandom));
      lat[8'(8'h10 + k)] = i_host.dat[k];
    end
    foreach (lat[p]) exp_q.push_back({16'h0105, 8'(p), mem[p] & lat[p]});
    i_host.frame(pp_pkg::OP_WREN, 24'h0, 0);
    i_host.frame(pp_pkg::OP_DPP, 24'h010510, 0);
    settle(40000);
    chk({status[1:0], flag_status[4], flag_status[1], 8'(exp_q.size())}, 32'h0);
    $display("short program test done");
    watch <= 1'b0;
    prog_fail_inj <= 1'b1;
    i_host.dat = {8'h00};
    i_host.frame(pp_pkg::OP_WREN, 24'h0, 0);
    i_host.frame(pp_pkg::OP_PP, 24'h010500, 0);
    settle(62000);
    chk({status[1:0], flag_status[4], flag_status[1]}, 32'h2);
    $display("timeout test done");
    tally_and_finish();
  end
endmodule
